//--- verilog/root_hub_port_state_control.sv
// Suspend, enable and connect state of the four root hub downstream ports.
//
// Contract
// - Clear-suspend write resumes only a suspended port.
// - Set-suspend sets suspend; resume end clears it.
// - Reset completion or bus resume clears suspend.
// - Suspend on disconnected port raises attach change.
// - Device wake on suspended port reaches controller.
// - Hardware enable clear also raises enable change.
// - Set/clear enable writes act; zeros ignored.
// - Reset or suspend completion sets enable.
// - Connect bit follows port, immune to writes.
// - Fixed devices always read as connected.
module root_hub_port_state_control
  import root_port_pkg::*;
(
  input  wire logic                  clk,                 // Core clock, 200 MHz.
  input  wire logic                  rst,                 // Asynchronous reset.
  input  wire logic                  reg_wr,              // Register write strobe.
  input  wire logic                  reg_rd,              // Register read strobe.
  input  wire logic [ADDR_W-1:0]     reg_addr,            // Register byte address.
  input  wire logic [31:0]           reg_wdata,           // Register write data.
  output logic      [31:0]           reg_rdata,           // Registered read data.
  input  wire logic [PORT_COUNT-1:0] attach_pin,          // Device present, raw pin.
  input  wire logic [PORT_COUNT-1:0] wake_pin,            // Device resume, raw pin.
  input  wire logic [PORT_COUNT-1:0] fixed_device_mask,   // Nonremovable device per port.
  input  wire port_causes_t          causes,              // Completion and fault events.
  input  wire logic                  hc_usb_resume,       // Controller enters bus resume.
  output logic      [PORT_COUNT-1:0] resume_start,        // Pulse: start resume signalling.
  output logic      [PORT_COUNT-1:0] upstream_wake,       // Pulse: device resume seen.
  output logic      [PORT_COUNT-1:0] attach_change_set,   // Pulse: raise attach change.
  output logic      [PORT_COUNT-1:0] enable_change_set,   // Pulse: raise enable change.
  output logic      [PORT_COUNT-1:0] suspend_state_flag,  // Port suspended.
  output logic      [PORT_COUNT-1:0] port_enabled_flag,   // Port enabled.
  output logic      [PORT_COUNT-1:0] attach_present_flag  // Port connected, registered.
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    port_state_t  [PORT_COUNT-1:0] port;
    port_events_t [PORT_COUNT-1:0] evt;
    logic         [31:0]           rdata;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;

  logic [2*PORT_COUNT-1:0] pins_sync;
  logic [PORT_COUNT-1:0]   attach_eff;
  logic [PORT_COUNT-1:0]   wake_sync;
  logic [PORT_COUNT-1:0]   hit_wr;
  logic [PORT_COUNT-1:0]   hit_rd;
  logic [PORT_COUNT-1:0]   fault;

  port_pin_sync u_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   ({wake_pin, attach_pin}),
    .pin_sync (pins_sync)
  );

  // ----------------------------------------------------------------
  // Address decode and connect level
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PORT_COUNT; g++)
    begin : g_port
      localparam logic [11:0] PORT_ADDR = OFFSET_PORT1 + PORT_STRIDE * 12'(g);
      assign hit_wr[g]     = reg_wr && (reg_addr == PORT_ADDR);
      assign hit_rd[g]     = reg_rd && (reg_addr == PORT_ADDR);
      assign attach_eff[g] = pins_sync[g] | fixed_device_mask[g];
      assign wake_sync[g]  = pins_sync[PORT_COUNT + g];
      assign fault[g]      = causes.overcurrent[g] | causes.power_off[g]
                           | causes.bus_error[g] | ~attach_eff[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.rdata = st.rdata;
    for (int i = 0; i < PORT_COUNT; i++)
    begin
      next_st.evt[i]              = RESET_EVENT;
      next_st.port[i].attach_prev = attach_eff[i];

      // Enable: software sets first, then completions, hardware clears win.
      if (hit_wr[i] && reg_wdata[BIT_SET_ENABLE])
      begin
        if (attach_eff[i])
          next_st.port[i].enabled = 1'h1;
        else
          next_st.evt[i].attach_change = 1'h1;
      end
      if (hit_wr[i] && reg_wdata[BIT_CLR_ENABLE])
        next_st.port[i].enabled = 1'h0;
      if ((causes.reset_change_flag[i] || causes.suspend_change_flag[i]) && attach_eff[i])
        next_st.port[i].enabled = 1'h1;
      if (fault[i])
      begin
        next_st.port[i].enabled = 1'h0;
        if (st.port[i].enabled)
          next_st.evt[i].enable_change = 1'h1;
      end

      // Suspend: set and resume requests, then clearing events.
      if (hit_wr[i] && reg_wdata[BIT_SET_SUSPEND])
      begin
        if (attach_eff[i])
          next_st.port[i].suspended = 1'h1;
        else
          next_st.evt[i].attach_change = 1'h1;
      end
      if (hit_wr[i] && reg_wdata[BIT_CLR_SUSPEND] && st.port[i].suspended
          && !st.port[i].resuming)
      begin
        next_st.port[i].resuming      = 1'h1;
        next_st.evt[i].resume_start   = 1'h1;
      end
      else if (wake_sync[i] && st.port[i].suspended && !st.port[i].resuming)
      begin
        next_st.port[i].resuming      = 1'h1;
        next_st.evt[i].upstream_wake  = 1'h1;
      end
      if (causes.suspend_change_flag[i])
      begin
        next_st.port[i].suspended = 1'h0;
        next_st.port[i].resuming  = 1'h0;
      end
      if (causes.reset_change_flag[i] || hc_usb_resume)
      begin
        next_st.port[i].suspended = 1'h0;
        next_st.port[i].resuming  = 1'h0;
      end
    end

    // Read data: connect bit is live and never written.
    if (reg_rd)
    begin
      next_st.rdata = RESET_RDATA;
      for (int i = 0; i < PORT_COUNT; i++)
      begin
        if (hit_rd[i])
        begin
          next_st.rdata[BIT_ATTACH]  = attach_eff[i];
          next_st.rdata[BIT_ENABLED] = st.port[i].enabled;
          next_st.rdata[BIT_SUSPEND] = st.port[i].suspended;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st.port  <= {PORT_COUNT{RESET_PORT}};
      st.evt   <= {PORT_COUNT{RESET_EVENT}};
      st.rdata <= RESET_RDATA;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st.rdata;

  generate
    for (g = 0; g < PORT_COUNT; g++)
    begin : g_out
      assign resume_start[g]        = st.evt[g].resume_start;
      assign upstream_wake[g]       = st.evt[g].upstream_wake;
      assign attach_change_set[g]   = st.evt[g].attach_change;
      assign enable_change_set[g]   = st.evt[g].enable_change;
      assign suspend_state_flag[g]  = st.port[g].suspended;
      assign port_enabled_flag[g]   = st.port[g].enabled;
      assign attach_present_flag[g] = st.port[g].attach_prev;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < PORT_COUNT; g++)
    begin : g_chk
      logic clears;
      assign clears = causes.suspend_change_flag[g] | causes.reset_change_flag[g]
                    | hc_usb_resume;

      a_resume_needs_suspend: assert property (@(posedge clk) disable iff (rst)
        hit_wr[g] && reg_wdata[BIT_CLR_SUSPEND] && !st.port[g].suspended
        |=> !resume_start[g])
        else $error("resume started on a port that was not suspended");

      a_resume_start_cause: assert property (@(posedge clk) disable iff (rst)
        resume_start[g] |-> $past(hit_wr[g]) && $past(reg_wdata[BIT_CLR_SUSPEND]))
        else $error("resume pulse without a clear-suspend write");

      a_suspend_sets: assert property (@(posedge clk) disable iff (rst)
        hit_wr[g] && reg_wdata[BIT_SET_SUSPEND] && attach_eff[g] && !clears
        |=> suspend_state_flag[g])
        else $error("set-suspend write did not suspend a connected port");

      a_suspend_ends: assert property (@(posedge clk) disable iff (rst)
        causes.suspend_change_flag[g] |=> !suspend_state_flag[g] ##1 !resume_start[g])
        else $error("suspend survived the end of resume");

      a_suspend_reset_clr: assert property (@(posedge clk) disable iff (rst)
        causes.reset_change_flag[g] || hc_usb_resume |=> !suspend_state_flag[g])
        else $error("suspend survived reset completion or bus resume");

      a_suspend_detached: assert property (@(posedge clk) disable iff (rst)
        hit_wr[g] && reg_wdata[BIT_SET_SUSPEND] && !attach_eff[g]
        |=> attach_change_set[g] && !$rose(suspend_state_flag[g]))
        else $error("suspend on a disconnected port misbehaved");

      a_wake_propagates: assert property (@(posedge clk) disable iff (rst)
        wake_sync[g] && st.port[g].suspended && !st.port[g].resuming
        && !(hit_wr[g] && reg_wdata[BIT_CLR_SUSPEND])
        |=> upstream_wake[g])
        else $error("device resume was not propagated");

      a_enable_drop_flag: assert property (@(posedge clk) disable iff (rst)
        port_enabled_flag[g] && fault[g] |=> !port_enabled_flag[g] && enable_change_set[g])
        else $error("hardware disable without enable change");

      a_enable_clear_cmd: assert property (@(posedge clk) disable iff (rst)
        hit_wr[g] && reg_wdata[BIT_CLR_ENABLE] && !reg_wdata[BIT_SET_ENABLE]
        && !causes.reset_change_flag[g] && !causes.suspend_change_flag[g]
        |=> !port_enabled_flag[g])
        else $error("clear-enable write did not disable the port");

      a_enable_set_cmd: assert property (@(posedge clk) disable iff (rst)
        hit_wr[g] && reg_wdata[BIT_SET_ENABLE] && !reg_wdata[BIT_CLR_ENABLE] && !fault[g]
        |=> port_enabled_flag[g])
        else $error("set-enable write did not enable the port");

      a_enable_needs_attach: assert property (@(posedge clk) disable iff (rst)
        port_enabled_flag[g] |-> $past(attach_eff[g], 1))
        else $error("port enabled while disconnected");

      a_enable_on_done: assert property (@(posedge clk) disable iff (rst)
        (causes.reset_change_flag[g] || causes.suspend_change_flag[g]) && !fault[g]
        |=> port_enabled_flag[g])
        else $error("completion did not enable the port");

      a_attach_readback: assert property (@(posedge clk) disable iff (rst)
        hit_rd[g] |=> reg_rdata[BIT_ATTACH] == $past(attach_eff[g])
                      && (reg_rdata[BIT_ATTACH] || !$past(fixed_device_mask[g])))
        else $error("connect bit read back wrongly");

      a_resume_one_pulse: assert property (@(posedge clk) disable iff (rst)
        resume_start[g] |=> !resume_start[g])
        else $error("resume pulse lasted more than one cycle");

      a_wake_one_pulse: assert property (@(posedge clk) disable iff (rst)
        upstream_wake[g] |=> !upstream_wake[g])
        else $error("device resume reported more than once");

      a_suspend_only_cmd: assert property (@(posedge clk) disable iff (rst)
        !(hit_wr[g] && reg_wdata[BIT_SET_SUSPEND]) |=> !$rose(suspend_state_flag[g]))
        else $error("suspend set without a set-suspend write to this port");

      a_enable_quiet: assert property (@(posedge clk) disable iff (rst)
        !hit_wr[g] && !fault[g] && !causes.reset_change_flag[g]
        && !causes.suspend_change_flag[g] |=> $stable(port_enabled_flag[g]))
        else $error("enable changed without a cause on this port");

      a_enable_detached: assert property (@(posedge clk) disable iff (rst)
        hit_wr[g] && reg_wdata[BIT_SET_ENABLE] && !attach_eff[g]
        |=> attach_change_set[g] && !port_enabled_flag[g])
        else $error("enable write on a disconnected port misbehaved");

      a_fixed_connected: assert property (@(posedge clk) disable iff (rst)
        fixed_device_mask[g] |=> attach_present_flag[g])
        else $error("nonremovable port not shown as connected");

      c_done_enable: cover property (@(posedge clk) disable iff (rst)
        causes.reset_change_flag[g] ##1 port_enabled_flag[g]);
      c_resume: cover property (@(posedge clk) disable iff (rst)
        suspend_state_flag[g] ##1 resume_start[g]);
      c_wake: cover property (@(posedge clk) disable iff (rst) upstream_wake[g]);
      c_enable_drop: cover property (@(posedge clk) disable iff (rst) enable_change_set[g]);
      c_detached_cmd: cover property (@(posedge clk) disable iff (rst) attach_change_set[g]);
    end
  endgenerate

endmodule // root_hub_port_state_control

//--- verilog/root_port_pkg.sv
// Constants and types shared by the root hub port state logic.
package root_port_pkg;

  // ----------------------------------------------------------------
  // Port map
  // ----------------------------------------------------------------
  localparam int          PORT_COUNT    = 4;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFFSET_PORT1  = 12'h054;
  localparam logic [11:0] PORT_STRIDE   = 12'h004;

  // ----------------------------------------------------------------
  // Write action bits
  // ----------------------------------------------------------------
  localparam int BIT_CLR_ENABLE  = 0;
  localparam int BIT_SET_ENABLE  = 1;
  localparam int BIT_SET_SUSPEND = 2;
  localparam int BIT_CLR_SUSPEND = 3;

  // ----------------------------------------------------------------
  // Read status bits
  // ----------------------------------------------------------------
  localparam int BIT_ATTACH  = 0;
  localparam int BIT_ENABLED = 1;
  localparam int BIT_SUSPEND = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_RDATA = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carried types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic suspended;
    logic resuming;
    logic enabled;
    logic attach_prev;
  } port_state_t;

  typedef struct packed {
    logic resume_start;
    logic upstream_wake;
    logic attach_change;
    logic enable_change;
  } port_events_t;

  typedef struct packed {
    logic [PORT_COUNT-1:0] overcurrent;
    logic [PORT_COUNT-1:0] power_off;
    logic [PORT_COUNT-1:0] bus_error;
    logic [PORT_COUNT-1:0] reset_change_flag;
    logic [PORT_COUNT-1:0] suspend_change_flag;
  } port_causes_t;

  localparam port_state_t  RESET_PORT  = '{default: 1'h0};
  localparam port_events_t RESET_EVENT = '{default: 1'h0};

endpackage : root_port_pkg

//--- verilog/port_pin_sync.sv
// Two-stage synchroniser for the attach and wake pins of all ports.
module port_pin_sync
  import root_port_pkg::*;
(
  input  wire logic                    clk,      // Core clock.
  input  wire logic                    rst,      // Asynchronous reset.
  input  wire logic [2*PORT_COUNT-1:0] pin_in,   // Raw pin levels.
  output logic      [2*PORT_COUNT-1:0] pin_sync  // Synchronised levels.
);

  typedef struct packed {
    logic [2*PORT_COUNT-1:0] meta;
    logic [2*PORT_COUNT-1:0] sync;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb
  begin
    next_st.meta = pin_in;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign pin_sync = st.sync;

endmodule // port_pin_sync

//--- dv/usb_device_model.sv
// Behavioural downstream device: attach presence and resume signalling per port.
module usb_device_model
  import root_port_pkg::*;
(
  input  wire logic                  clk,        // Core clock.
  input  wire logic                  rst,        // Asynchronous reset.
  input  wire logic [PORT_COUNT-1:0] plugged,    // Device attached per port.
  input  wire logic [PORT_COUNT-1:0] wake_req,   // Pulse: start a resume.
  output logic      [PORT_COUNT-1:0] attach_pin, // Device present.
  output logic      [PORT_COUNT-1:0] wake_pin    // Resume signalling level.
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] hold [PORT_COUNT];

  // A resume is only signalled by a device that is attached.
  always @(posedge clk or posedge rst)
  begin
    for (int i = 0; i < PORT_COUNT; i++)
    begin
      if (rst)
        hold[i] <= 3'h0;
      else if (wake_req[i] && plugged[i])
        hold[i] <= 3'h4;
      else if (hold[i] != 3'h0)
        hold[i] <= hold[i] - 3'h1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < PORT_COUNT; i++)
      wake_pin[i] = (hold[i] != 3'h0);
  end

  assign attach_pin = plugged;
endmodule // usb_device_model

//--- dv/test_root_hub_port_state_control.sv
// Self-checking bench for the root hub port state logic.
module test_root_hub_port_state_control
  import root_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk, rst, reg_wr, reg_rd, hc_usb_resume, rd_seen;
  logic [ADDR_W-1:0]     reg_addr;
  logic [31:0]           reg_wdata, reg_rdata;
  logic [PORT_COUNT-1:0] fixed_device_mask, plugged, wake_req, attach_pin, wake_pin;
  logic [PORT_COUNT-1:0] resume_start, upstream_wake, attach_change_set, enable_change_set;
  logic [PORT_COUNT-1:0] suspend_state_flag, port_enabled_flag, attach_present_flag;
  port_causes_t          causes;
  logic [31:0]           rd_q[$];
  logic [15:0]           ev_q[$];
  logic [2:0]            fl_q[$];
  int                    rp_q[$];
  int                    miscompares, total_checks, cycles, seed;

  root_hub_port_state_control u_root_hub_port_state_control (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .attach_pin(attach_pin),
    .wake_pin(wake_pin), .fixed_device_mask(fixed_device_mask), .causes(causes),
    .hc_usb_resume(hc_usb_resume), .resume_start(resume_start),
    .upstream_wake(upstream_wake), .attach_change_set(attach_change_set),
    .enable_change_set(enable_change_set), .suspend_state_flag(suspend_state_flag),
    .port_enabled_flag(port_enabled_flag), .attach_present_flag(attach_present_flag));

  usb_device_model u_usb_device_model (
    .clk(clk), .rst(rst), .plugged(plugged), .wake_req(wake_req),
    .attach_pin(attach_pin), .wake_pin(wake_pin));

  // ----------------------------------------------------------------
  // Clock, timeout and result checking
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    rd_seen <= reg_rd;
    if (cycles == 5000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic note(input logic [31:0] exp_v, input logic [31:0] got_v);
    total_checks++;
    if (got_v !== exp_v)
    begin
      miscompares++;
      $display("unexpected at %0t: expected %h got %h", $time, exp_v, got_v);
    end
  endtask

  task automatic cmp_rd();
    note(rd_q.size() ? rd_q.pop_front() : 'x, reg_rdata);
  endtask

  task automatic cmp_ev();
    note(ev_q.size() ? {16'h0, ev_q.pop_front()} : 'x,
         {16'h0, resume_start, upstream_wake, attach_change_set, enable_change_set});
  endtask

  // Status levels of the port just read must agree with its read data.
  task automatic cmp_fl();
    int         p;
    logic [2:0] e;
    p = rp_q.pop_front();
    e = fl_q.pop_front();
    if (p < PORT_COUNT)
      note({29'h0, e},
           {29'h0, suspend_state_flag[p], port_enabled_flag[p], attach_present_flag[p]});
  endtask

  // Read data is checked once, in the cycle after its read; event pulses in the one cycle they stand.
  always @(negedge clk)
  begin
    if (rd_seen)
    begin
      cmp_rd();
      cmp_fl();
    end
    if (|{resume_start, upstream_wake, attach_change_set, enable_change_set})
      cmp_ev();
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic bus(input bit wr, input int port, input logic [3:0] d);
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk);
    reg_wr    <= wr;
    reg_rd    <= !wr;
    reg_addr  <= OFFSET_PORT1 + PORT_STRIDE * 12'(port);
    reg_wdata <= {r[31:4], d};
    @(posedge clk);
    reg_wr    <= 1'h0;
    reg_rd    <= 1'h0;
  endtask

  task automatic wx(input int port, input logic [3:0] d, input logic [15:0] ev);
    if (ev != 16'h0)
      ev_q.push_back(ev);
    bus(1'h1, port, d);
  endtask

  task automatic rd(input int port, input logic [31:0] exp_v);
    rd_q.push_back(exp_v);
    rp_q.push_back(port);
    fl_q.push_back(exp_v[2:0]);
    bus(1'h0, port, 4'h0);
  endtask

  task automatic cause(input int k, input int port);
    @(posedge clk);
    causes <= port_causes_t'(20'h1 << (4 * k + port));
    @(posedge clk);
    causes <= '0;
    repeat (2) @(posedge clk);
  endtask

  task automatic do_wake(input int port);
    @(posedge clk);
    wake_req <= 4'(1 << port);
    @(posedge clk);
    wake_req <= 4'h0;
    repeat (8) @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    seed = 21439;
    {rst, reg_wr, reg_rd, hc_usb_resume} = 4'h8;
    {reg_addr, reg_wdata, causes} = '0;
    {fixed_device_mask, plugged, wake_req} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    for (int p = 0; p < PORT_COUNT; p++)
      rd(p, RESET_RDATA);
    rd(9, 32'h0);
    wx(1, 4'h2, 16'h0020);
    wx(1, 4'h4, 16'h0020);
    rd(1, 32'h0);
    fixed_device_mask <= 4'h8;
    rd(3, 32'h1);
    wx(3, 4'h2, 16'h0);
    rd(3, 32'h3);
    plugged <= 4'h1;
    repeat (4) @(posedge clk);
    rd(0, 32'h1);
    wx(0, 4'h2, 16'h0);
    rd(0, 32'h3);
    wx(0, 4'h0, 16'h0);
    rd(0, 32'h3);
    wx(0, 4'h1, 16'h0);
    rd(0, 32'h1);
    wx(0, 4'h8, 16'h0);
    wx(0, 4'h6, 16'h0);
    rd(0, 32'h7);
    rd(1, 32'h0);
    wx(0, 4'h1, 16'h0);
    wx(0, 4'h8, 16'h1000);
    wx(0, 4'h8, 16'h0);
    rd(0, 32'h5);
    cause(0, 0);
    rd(0, 32'h3);
    wx(0, 4'h4, 16'h0);
    ev_q.push_back(16'h0100);
    do_wake(0);
    @(posedge clk);
    hc_usb_resume <= 1'h1;
    @(posedge clk);
    hc_usb_resume <= 1'h0;
    rd(0, 32'h3);
    wx(0, 4'h4, 16'h0);
    wx(0, 4'h1, 16'h0);
    cause(1, 0);
    rd(0, 32'h3);
    do_wake(0);
    for (int k = 2; k <= 4; k++)
    begin
      wx(0, 4'h2, 16'h0001);
      cause(k, 0);
      rd(0, 32'h1);
    end
    wx(0, 4'h2, 16'h0001);
    plugged <= 4'h0;
    repeat (6) @(posedge clk);
    rd(0, 32'h0);
    repeat (4) @(posedge clk);
    note(32'h0, 32'(rd_q.size() + ev_q.size()));
    give_verdict();
  end
endmodule // test_root_hub_port_state_control
